//--- pkg/ext_bus_pkg.sv
// constants for the external bus interface with its wait-state generator
// assumes a single machine clock; the core drives one request at a time per kind
package ext_bus_pkg;
    localparam logic [15:0] WAIT_CFG_ADDR      = 16'hFFFF;
    localparam logic [15:0] WAIT_CFG_RESET     = 16'h000F;
    localparam int          PROG_WAIT_POS      = 0;
    localparam int          DATA_WAIT_POS      = 1;
    localparam int          IO_WAIT_POS        = 2;
    localparam int          TRACE_POS          = 3;
    localparam logic [15:0] WAIT_CFG_MASK      = 16'h000F;
    localparam int          RESET_MIN_CYCLES   = 6;
    localparam int          FETCH_DELAY_CYCLES = 16;
    localparam logic [4:0]  FETCH_DELAY        = 5'h10;
    localparam logic [2:0]  RESET_MIN          = 3'h6;

    typedef enum logic [1:0] {
        SPACE_PROG,
        SPACE_DATA,
        SPACE_IO
    } space_e;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_READ,
        OP_FETCH,
        OP_NONE
    } op_e;
endpackage

//--- core/reset_filter.sv
// reset combiner: either reset pin, held six cycles, starts an internal reset
// assumes both reset pins are sampled on ref_clk
module reset_filter
    import ext_bus_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic reset_active_high,
    input  wire logic reset_active_low_n,
    output logic      core_reset,
    output logic      run_enable
);
    typedef struct packed {
        logic [2:0] held;
        logic [4:0] delay;
        logic       in_reset;
        logic       run;
    } filt_s;

    filt_s st;
    filt_s next_st;
    logic  req;

    always_comb begin
        next_st = st;
        req = reset_active_high | ~reset_active_low_n;
        if (req) begin
            if (st.held != RESET_MIN) begin
                next_st.held = st.held + 3'h1;
            end
            // a request shorter than six cycles is not guaranteed to reset
            if (st.held >= RESET_MIN - 3'h1) begin
                next_st.in_reset = 1'b1;
                next_st.run = 1'b0;
                next_st.delay = 5'h00;
            end
        end else begin
            next_st.held = 3'h0;
            next_st.in_reset = 1'b0;
            if (!st.run) begin
                if (st.delay == FETCH_DELAY - 5'h1) begin
                    next_st.run = 1'b1;
                end else begin
                    next_st.delay = st.delay + 5'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '{held: 3'h0, delay: 5'h00, in_reset: 1'b1, run: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign core_reset = st.in_reset | rst;
    assign run_enable = st.run;
endmodule

//--- core/external_bus_wait_state_interface.sv
// external memory and I/O bus sequencer with the one-wait-state generator
// assumes the core holds its request lines until the matching done pulse
// Functional notes
// - read_write_n shows read (1) or write (0) for every external cycle.
// - cycle_strobe_n frames every external cycle in any space.
// - read_strobe_n and write_enable_n active only in their own cycle type.
// - cycle stalls while ready is low, resumes once it is high.
// - global data access asserts bus request from the access start.
// - reads may take one cycle; writes always take at least two.
// - data drivers turn on and off half a cycle from neighbouring cycles.
// - waits are whole cycles from ready or generator; ready waits unbounded.
// - a set space bit inserts one wait that ready cannot cancel.
// - trace bit drives program address onto idle bus, adds no wait.
// - reset sets the four configuration bits to one.
// - configuration register lives at I/O address FFFF.
// - either reset polarity resets; hold it at least six cycles.
// - first fetch about sixteen cycles after reset release.
// - reset aborts any bus cycle immediately, writes included.
// - same-cycle write, read and fetch run write, read, fetch.
// - bits 0-3 program, data, I/O waits and trace; 15-4 read zero.
// - bus request is active low with address timing.
module external_bus_wait_state_interface
    import ext_bus_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        reset_active_high,
    input  wire logic        reset_active_low_n,
    input  wire logic        ready,
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        read_req,
    input  wire logic        read_space_io,
    input  wire logic        read_global,
    input  wire logic [15:0] read_addr,
    input  wire logic        write_req,
    input  wire logic        write_space_io,
    input  wire logic        write_global,
    input  wire logic [15:0] write_addr,
    input  wire logic [15:0] write_data,
    input  wire logic [15:0] program_counter,
    input  wire logic [15:0] data_in,
    output logic             fetch_done,
    output logic             read_done,
    output logic             write_done,
    output logic [15:0]      read_data,
    output logic [15:0]      address,
    output logic [15:0]      data_out,
    output logic             data_oe,
    output logic             read_write_n,
    output logic             cycle_strobe_n,
    output logic             read_strobe_n,
    output logic             write_enable_n,
    output logic             global_bus_request_n,
    output logic             program_select_n,
    output logic             data_select_n,
    output logic             io_select_n,
    output logic             core_running
);
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACCESS,
        BUS_GEN_WAIT,
        BUS_WRITE_TAIL
    } bus_e;

    typedef struct packed {
        bus_e        phase;
        op_e         op;
        space_e      space;
        logic        internal;
        logic [3:0]  wait_config;
        logic        fetch_done;
        logic        read_done;
        logic        write_done;
        logic [15:0] read_data;
        logic [15:0] address;
        logic [15:0] data_out;
        logic        data_oe;
        logic        read_write_n;
        logic        cycle_strobe_n;
        logic        read_strobe_n;
        logic        write_enable_n;
        logic        global_bus_request_n;
        logic        program_select_n;
        logic        data_select_n;
        logic        io_select_n;
        logic        core_running;
    } bus_s;

    bus_s st;
    bus_s next_st;
    logic core_reset;
    logic run_enable;

    reset_filter u_reset_filter (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .reset_active_high  (reset_active_high),
        .reset_active_low_n (reset_active_low_n),
        .core_reset         (core_reset),
        .run_enable         (run_enable)
    );

    // wait-state enable bit for a given space
    function automatic logic space_wait(input logic [3:0] cfg, input space_e sp);
        unique case (sp)
            SPACE_PROG: space_wait = cfg[PROG_WAIT_POS];
            SPACE_DATA: space_wait = cfg[DATA_WAIT_POS];
            SPACE_IO:   space_wait = cfg[IO_WAIT_POS];
            default:    space_wait = 1'b0;
        endcase
    endfunction

    function automatic logic is_config(input logic io, input logic [15:0] addr);
        is_config = io && (addr == WAIT_CFG_ADDR);
    endfunction

    bus_s reset_value;
    always_comb begin
        reset_value = '0;
        reset_value.phase = BUS_IDLE;
        reset_value.op = OP_NONE;
        reset_value.space = SPACE_PROG;
        reset_value.wait_config = WAIT_CFG_RESET[3:0];
        reset_value.read_write_n = 1'b1;
        reset_value.cycle_strobe_n = 1'b1;
        reset_value.read_strobe_n = 1'b1;
        reset_value.write_enable_n = 1'b1;
        reset_value.global_bus_request_n = 1'b1;
        reset_value.program_select_n = 1'b1;
        reset_value.data_select_n = 1'b1;
        reset_value.io_select_n = 1'b1;
    end

    logic        do_finish;
    logic        glob;
    space_e      sp;
    logic [15:0] addr;
    always_comb begin
        next_st = st;
        next_st.fetch_done = 1'b0;
        next_st.read_done = 1'b0;
        next_st.write_done = 1'b0;
        next_st.core_running = run_enable;
        do_finish = 1'b0;
        glob = 1'b0;
        sp = SPACE_PROG;
        addr = 16'h0000;
        unique case (st.phase)
            BUS_IDLE: begin
                next_st.cycle_strobe_n = 1'b1;
                next_st.read_strobe_n = 1'b1;
                next_st.write_enable_n = 1'b1;
                next_st.read_write_n = 1'b1;
                next_st.global_bus_request_n = 1'b1;
                next_st.program_select_n = 1'b1;
                next_st.data_select_n = 1'b1;
                next_st.io_select_n = 1'b1;
                next_st.data_oe = 1'b0;
                next_st.op = OP_NONE;
                if (run_enable) begin
                    if (write_req) begin
                        next_st.op = OP_WRITE;
                        sp = write_space_io ? SPACE_IO : SPACE_DATA;
                        addr = write_addr;
                        glob = write_global & ~write_space_io;
                    end else if (read_req) begin
                        next_st.op = OP_READ;
                        sp = read_space_io ? SPACE_IO : SPACE_DATA;
                        addr = read_addr;
                        glob = read_global & ~read_space_io;
                    end else if (fetch_req) begin
                        next_st.op = OP_FETCH;
                        sp = SPACE_PROG;
                        addr = fetch_addr;
                    end
                end
                if (next_st.op != OP_NONE) begin
                    next_st.space = sp;
                    next_st.address = addr;
                    // config register is internal but still waits for ready
                    next_st.internal = is_config(sp == SPACE_IO, addr);
                    next_st.phase = BUS_ACCESS;
                    next_st.cycle_strobe_n = 1'b0;
                    next_st.read_write_n = (next_st.op != OP_WRITE);
                    next_st.read_strobe_n = (next_st.op == OP_WRITE);
                    next_st.global_bus_request_n = ~glob;
                    next_st.program_select_n = (sp != SPACE_PROG);
                    next_st.data_select_n = (sp != SPACE_DATA);
                    next_st.io_select_n = (sp != SPACE_IO);
                    if (next_st.op == OP_WRITE) begin
                        next_st.data_out = write_data;
                    end
                end else if (st.wait_config[TRACE_POS]) begin
                    next_st.address = program_counter;
                end
            end
            BUS_ACCESS: begin
                // write drivers and enable open one cycle late: half-cycle gap kept
                if (st.op == OP_WRITE) begin
                    next_st.data_oe = 1'b1;
                    next_st.write_enable_n = 1'b0;
                end
                if (space_wait(st.wait_config, st.space)) begin
                    next_st.phase = BUS_GEN_WAIT;
                end else if (ready) begin
                    if (st.op == OP_WRITE) begin
                        next_st.phase = BUS_WRITE_TAIL;
                    end else begin
                        do_finish = 1'b1;
                    end
                end
            end
            BUS_GEN_WAIT: begin
                if (ready) begin
                    if (st.op == OP_WRITE) begin
                        next_st.phase = BUS_WRITE_TAIL;
                    end else begin
                        do_finish = 1'b1;
                    end
                end
            end
            BUS_WRITE_TAIL: begin
                do_finish = 1'b1;
            end
            default: begin
                next_st.phase = BUS_IDLE;
            end
        endcase

        if (do_finish) begin
            next_st.phase = BUS_IDLE;
            next_st.cycle_strobe_n = 1'b1;
            next_st.read_strobe_n = 1'b1;
            next_st.write_enable_n = 1'b1;
            next_st.data_oe = 1'b0;
            next_st.global_bus_request_n = 1'b1;
            unique case (st.op)
                OP_WRITE: begin
                    next_st.write_done = 1'b1;
                    if (st.internal) begin
                        next_st.wait_config = st.data_out[3:0];
                    end
                end
                OP_READ: begin
                    next_st.read_done = 1'b1;
                    next_st.read_data = st.internal ?
                        ({12'h000, st.wait_config} & WAIT_CFG_MASK) : data_in;
                end
                OP_FETCH: begin
                    next_st.fetch_done = 1'b1;
                    next_st.read_data = data_in;
                end
                default: begin
                    next_st.phase = BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || core_reset) begin
            st <= reset_value;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign fetch_done           = st.fetch_done;
    assign read_done            = st.read_done;
    assign write_done           = st.write_done;
    assign read_data            = st.read_data;
    assign address              = st.address;
    assign data_out             = st.data_out;
    assign data_oe              = st.data_oe;
    assign read_write_n         = st.read_write_n;
    assign cycle_strobe_n       = st.cycle_strobe_n;
    assign read_strobe_n        = st.read_strobe_n;
    assign write_enable_n       = st.write_enable_n;
    assign global_bus_request_n = st.global_bus_request_n;
    assign program_select_n     = st.program_select_n;
    assign data_select_n        = st.data_select_n;
    assign io_select_n          = st.io_select_n;
    assign core_running         = st.core_running;
endmodule

//--- verification/bus_props.sv
// assertion checker for the external bus interface, bound onto its top module
// assumes single ref_clk domain with synchronous active-high rst
module bus_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ready,
    input wire logic read_req,
    input wire logic read_global,
    input wire logic fetch_done,
    input wire logic read_done,
    input wire logic write_done,
    input wire logic read_write_n,
    input wire logic cycle_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_enable_n,
    input wire logic global_bus_request_n,
    input wire logic data_select_n,
    input wire logic program_select_n,
    input wire logic io_select_n,
    input wire logic data_oe,
    input wire logic core_running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_read_strobe_dir: assert property (!read_strobe_n |-> !cycle_strobe_n && read_write_n)
        else $error("read strobe outside a read cycle");
    a_write_enable_dir: assert property (!write_enable_n |-> !cycle_strobe_n && !read_write_n)
        else $error("write enable outside a write cycle");
    a_drive_gap_write: assert property ($rose(data_oe) |-> !read_write_n && $past(cycle_strobe_n) == 1'b0)
        else $error("data drivers on without a half-cycle gap");
    a_write_two_cycles: assert property ($fell(cycle_strobe_n) && !read_write_n |=> !cycle_strobe_n)
        else $error("write shorter than two cycles");
    // a write samples ready in every cycle before its tail except an access cycle with its space wait bit set; the tail ends regardless
    a_ready_stall_cycle: assert property (!cycle_strobe_n && !ready && (read_write_n || write_enable_n) |=> !(read_done || write_done || fetch_done))
        else $error("access finished while ready was low");
    a_global_read_req: assert property (!cycle_strobe_n && read_write_n && !data_select_n && read_req && read_global |-> !global_bus_request_n)
        else $error("global read without bus request");
    a_request_data_only: assert property (!global_bus_request_n |-> !data_select_n)
        else $error("bus request outside data space");
    a_space_select_one: assert property (!cycle_strobe_n |-> $onehot({!program_select_n, !data_select_n, !io_select_n}))
        else $error("strobed cycle without exactly one space select");
    a_done_one_hot: assert property ($onehot0({fetch_done, read_done, write_done}))
        else $error("two accesses finished together");
    a_reset_bus_idle: assert property (disable iff (1'b0) rst |=> cycle_strobe_n && write_enable_n && !data_oe)
        else $error("bus not idle after reset");
    a_fetch_start_delay: assert property ($fell(rst) |-> !core_running [*8])
        else $error("fetching started too soon after reset");
    a_halted_no_strobe: assert property (!core_running && $past(core_running) == 1'b0 |-> cycle_strobe_n)
        else $error("bus cycle while halted");
endmodule

bind external_bus_wait_state_interface bus_props u_props (
    .ref_clk, .rst, .ready, .read_req, .read_global, .fetch_done, .read_done, .write_done,
    .read_write_n, .cycle_strobe_n, .read_strobe_n, .write_enable_n, .global_bus_request_n,
    .data_select_n, .program_select_n, .io_select_n, .data_oe, .core_running
);

//--- verification/mem_partner.sv
// far-side memory with a programmable ready delay
// assumes strobes and data_oe come from the bus interface under test
module mem_partner (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  slow,
    input  wire logic        cycle_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_enable_n,
    input  wire logic        data_oe,
    input  wire logic [15:0] address,
    input  wire logic [15:0] data_out,
    output logic             ready,
    output logic [15:0]      data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16] = '{default: 16'h0000};
    int          cnt = 0;
    always @(posedge ref_clk) begin
        cnt <= cycle_strobe_n ? 0 : cnt + 1;
        if (!write_enable_n && data_oe)
            mem[address[3:0]] <= data_out;
    end
    // low for the first slow strobe cycles, high otherwise and at boot
    assign ready = cycle_strobe_n || cnt >= int'(slow);
    // an unselected bus shows the inverse word
    assign data_in = read_strobe_n ? ~mem[address[3:0]] : mem[address[3:0]];
endmodule

//--- verification/tb_top.sv
// self-checking bench for the external bus interface and its wait-state generator
// assumes mem_partner on the far side and bus_props bound onto the design
module tb_top
    import ext_bus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic        reset_active_high = 1'b0, reset_active_low_n = 1'b1;
    logic        fetch_req = 1'b0, read_req = 1'b0, write_req = 1'b0;
    logic        read_space_io = 1'b0, write_space_io = 1'b0;
    logic        read_global = 1'b0, write_global = 1'b0;
    logic [15:0] fetch_addr = 16'h0000, read_addr = 16'h0000, write_addr = 16'h0000;
    logic [15:0] write_data = 16'h0000, program_counter = 16'h0000, pc;
    logic [3:0]  slow = 4'h0;
    logic        ready, fetch_done, read_done, write_done, data_oe, read_write_n;
    logic        cycle_strobe_n, read_strobe_n, write_enable_n, global_bus_request_n;
    logic        program_select_n, data_select_n, io_select_n, core_running;
    logic [15:0] data_in, read_data, address, data_out;
    logic [15:0] cfg_m = WAIT_CFG_RESET;
    logic [15:0] mem_m [16] = '{default: 16'h0000};
    int          err_total = 0, checks_done = 0, cyc = 0, lat, base, t, ord;

    external_bus_wait_state_interface uut (
        .ref_clk, .rst, .clk_en, .reset_active_high, .reset_active_low_n, .ready, .fetch_req,
        .fetch_addr, .read_req, .read_space_io, .read_global, .read_addr, .write_req,
        .write_space_io, .write_global, .write_addr, .write_data, .program_counter, .data_in,
        .fetch_done, .read_done, .write_done, .read_data, .address, .data_out, .data_oe,
        .read_write_n, .cycle_strobe_n, .read_strobe_n, .write_enable_n, .global_bus_request_n,
        .program_select_n, .data_select_n, .io_select_n, .core_running
    );
    mem_partner far (
        .ref_clk, .slow, .cycle_strobe_n, .read_strobe_n, .write_enable_n, .data_oe, .address,
        .data_out, .ready, .data_in
    );

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    // kind 0 write, 1 read, 2 fetch; request held until its done pulse
    task automatic access(input int kind, input logic io, g, input logic [15:0] a, d);
        @(negedge ref_clk);
        {write_req, read_req, fetch_req} = {kind == 0, kind == 1, kind == 2};
        {write_space_io, read_space_io, write_global, read_global} = {io, io, g, g};
        {write_addr, read_addr, fetch_addr, write_data} = {a, a, a, d};
        lat = 0;
        do begin
            @(negedge ref_clk);
            lat++;
        end while (!(write_done || read_done || fetch_done) && lat < 200);
        {write_req, read_req, fetch_req} = 3'h0;
    endtask

    task automatic rd(input logic io, g, input logic [15:0] a);
        access(1, io, g, a, 16'h0000);
        chk("read_data", (io && a == WAIT_CFG_ADDR) ? cfg_m : mem_m[a[3:0]], read_data);
    endtask

    task automatic wr(input logic io, input logic [15:0] a, d);
        access(0, io, 1'b0, a, d);
        mem_m[a[3:0]] = d;
        if (io && a == WAIT_CFG_ADDR)
            cfg_m = d & WAIT_CFG_MASK;
    endtask

    task automatic wait_run();
        t = 0;
        while (core_running !== 1'b1 && t < 100) begin
            @(negedge ref_clk);
            t++;
        end
    endtask

    initial begin
        void'($urandom(32'h025E));
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        wait_run();
        rd(1'b1, 1'b0, WAIT_CFG_ADDR);
        wr(1'b1, WAIT_CFG_ADDR, 16'($urandom));
        rd(1'b1, 1'b0, WAIT_CFG_ADDR);
        $display("test config done");
        for (int s = 0; s < 3; s++) begin
            wr(1'b1, WAIT_CFG_ADDR, 16'h0000);
            access(s == 0 ? 2 : 1, s == 2, 1'b0, 16'h0003, 16'h0000);
            base = lat;
            wr(1'b1, WAIT_CFG_ADDR, 16'h0001 << s);
            access(s == 0 ? 2 : 1, s == 2, 1'b0, 16'h0003, 16'h0000);
            chk("generated_wait", 16'(base + 1), 16'(lat));
        end
        wr(1'b1, WAIT_CFG_ADDR, 16'h0000);
        rd(1'b0, 1'b1, 16'h0005);
        base = lat;
        slow = 4'($urandom_range(6, 1));
        rd(1'b0, 1'b1, 16'h0005);
        chk("ready_wait", 16'(base + int'(slow)), 16'(lat));
        slow = 4'h0;
        $display("test wait states done");
        for (int i = 0; i < 8; i++) begin
            pc = 16'($urandom);
            wr(1'b0, pc, 16'($urandom));
            chk("write_length", 16'(lat > base), 16'h0001);
            rd(1'b0, pc[0], pc);
        end
        $display("test traffic done");
        wr(1'b1, WAIT_CFG_ADDR, 16'h0008);
        program_counter = 16'($urandom);
        repeat (3) @(negedge ref_clk);
        chk("trace_address", program_counter, address);
        clk_en = 1'b0;
        program_counter = ~program_counter;
        repeat (3) @(negedge ref_clk);
        chk("freeze_address", ~program_counter, address);
        clk_en = 1'b1;
        rd(1'b0, 1'b0, 16'h0005);
        chk("trace_no_wait", 16'(base), 16'(lat));
        wr(1'b1, WAIT_CFG_ADDR, 16'h0000);
        program_counter = ~address;
        repeat (3) @(negedge ref_clk);
        chk("trace_off", 16'(address === program_counter), 16'h0000);
        $display("test trace done");
        ord = 0;
        t = 0;
        {write_addr, read_addr, write_data} = {16'h0009, 16'h0009, 16'($urandom)};
        {write_space_io, read_space_io, write_global, read_global} = 4'h0;
        {write_req, read_req, fetch_req} = 3'h7;
        while (ord < 16 && t < 300) begin
            @(negedge ref_clk);
            t++;
            if (write_done === 1'b1)
                {write_req, ord} = {1'b0, ord * 4 + 1};
            if (read_done === 1'b1)
                {read_req, ord} = {1'b0, ord * 4 + 2};
            if (fetch_done === 1'b1)
                {fetch_req, ord} = {1'b0, ord * 4 + 3};
        end
        chk("order", 16'h001B, 16'(ord));
        mem_m[9] = write_data;
        rd(1'b0, 1'b0, 16'h0009);
        $display("test ordering done");
        for (int p = 0; p < 2; p++) begin
            {write_addr, write_req} = {16'h000C, 1'b1};
            repeat (2) @(negedge ref_clk);
            {reset_active_high, reset_active_low_n} = {p == 0, p == 0};
            // the abort lands one edge after the sixth sampled cycle
            repeat (RESET_MIN_CYCLES + 1) @(negedge ref_clk);
            chk("abort_write", 16'({cycle_strobe_n, write_enable_n, data_oe, write_done}), 16'h000C);
            {write_req, reset_active_high, reset_active_low_n} = 3'h1;
            wait_run();
            chk("fetch_delay", 16'(t >= 14 && t <= 20), 16'h0001);
            cfg_m = WAIT_CFG_RESET;
            rd(1'b1, 1'b0, WAIT_CFG_ADDR);
        end
        $display("test pin reset done");
        close_out();
    end
endmodule
